//--- lock_select_pkg.sv
// Shared constants, types and register map for fault-reset and local-lock selection
package lock_select_pkg;

    localparam int NUM_DI     = 5;
    localparam int WORD_WIDTH = 16;
    localparam int ADDR_WIDTH = 8;

    // Selector code, signed so that inverted inputs read as -1 .. -5
    typedef logic signed [4:0] sel_t;

    localparam sel_t SEL_PANEL    = 5'sh00;
    localparam sel_t SEL_LOCK_OFF = 5'sh00;
    localparam sel_t SEL_STOP     = 5'sh07;
    localparam sel_t SEL_LOCK_ON  = 5'sh07;
    localparam sel_t SEL_FIELDBUS = 5'sh08;
    localparam sel_t SEL_DEFAULT  = 5'sh02;

    // Fieldbus bit positions
    localparam int FB_RESET_BIT  = 4;
    localparam int EFB_RESET_BIT = 7;
    localparam int FB_LOCK_BIT   = 14;

    // Register byte addresses
    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET_SEL = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] ADDR_LOCK_SEL  = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] ADDR_CONTROL   = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS    = 8'h0C;

    // Field positions
    localparam int CTRL_ALT_PROFILE = 0;
    localparam int STAT_LOCK_ACTIVE = 0;
    localparam int STAT_LOCAL_MODE  = 1;

    typedef struct packed {
        logic alt_profile;
        sel_t lock_sel;
        sel_t reset_sel;
    } cfg_t;

    typedef struct packed {
        logic reset_key;
        logic stop_key;
        logic local_remote_key;
    } panel_t;

    typedef struct packed {
        logic [WORD_WIDTH-1:0] fieldbus_command_word_one;
        logic [WORD_WIDTH-1:0] embedded_fieldbus_param_nineteen;
    } fieldbus_t;

endpackage : lock_select_pkg

//--- input_edge_sync.sv
// Digital input synchroniser with one-cycle edge pulses
`timescale 1ns/100ps
module input_edge_sync #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    // Inputs and edges
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] stage_a;
    logic [WIDTH-1:0] stage_b;
    logic [WIDTH-1:0] prev;

    genvar k;
    generate
        for (k = 0; k < WIDTH; k++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_a[k] <= 1'b0;
                    stage_b[k] <= 1'b0;
                    prev[k]    <= 1'b0;
                end else if (ce) begin
                    stage_a[k] <= raw[k];
                    stage_b[k] <= stage_a[k];
                    prev[k]    <= stage_b[k];
                end
            end
            assign rise[k] = stage_b[k] & ~prev[k];
            assign fall[k] = ~stage_b[k] & prev[k];

            edge_single_a: assert property (@(posedge pclk) disable iff (!presetn)
                ce && (rise[k] || fall[k]) |=> !(rise[k] || fall[k]))
                else $error("edge pulse lasted more than one cycle");
        end
    endgenerate

endmodule : input_edge_sync

//--- apb_cfg_regs.sv
// APB slave holding the selector registers and reading back status
`timescale 1ns/100ps
module apb_cfg_regs
    import lock_select_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    // APB
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Block side
    input  wire logic                  lock_active,
    input  wire logic                  local_mode,
    output lock_select_pkg::cfg_t      cfg
);
    logic        access;
    logic        commit;
    logic        hit_reset;
    logic        hit_lock;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        mapped;
    logic [31:0] read_word;

    assign access    = psel & penable & ~pready;
    assign commit    = psel & penable & pready & pwrite;
    assign hit_reset = (paddr == ADDR_RESET_SEL);
    assign hit_lock  = (paddr == ADDR_LOCK_SEL);
    assign hit_ctrl  = (paddr == ADDR_CONTROL);
    assign hit_stat  = (paddr == ADDR_STATUS);
    assign mapped    = hit_reset | hit_lock | hit_ctrl | hit_stat;

    always_comb begin
        read_word = '0;
        if (hit_reset)
            read_word = {{27{cfg.reset_sel[4]}}, cfg.reset_sel};
        else if (hit_lock)
            read_word = {{27{cfg.lock_sel[4]}}, cfg.lock_sel};
        else if (hit_ctrl)
            read_word[CTRL_ALT_PROFILE] = cfg.alt_profile;
        else if (hit_stat) begin
            read_word[STAT_LOCK_ACTIVE] = lock_active;
            read_word[STAT_LOCAL_MODE]  = local_mode;
        end
    end

    // One wait state: answer in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready  <= access;
            pslverr <= access & ~mapped;
            prdata  <= (access && !pwrite) ? read_word : '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.reset_sel   <= SEL_DEFAULT;
            cfg.lock_sel    <= SEL_DEFAULT;
            cfg.alt_profile <= 1'b0;
        end else if (ce && commit) begin
            if (hit_reset)
                cfg.reset_sel <= sel_t'(pwdata[4:0]);
            if (hit_lock)
                cfg.lock_sel <= sel_t'(pwdata[4:0]);
            if (hit_ctrl)
                cfg.alt_profile <= pwdata[CTRL_ALT_PROFILE];
        end
    end

endmodule : apb_cfg_regs

//--- reset_lock_select.sv
// Fault-reset source and local-control lock selection for the drive
`timescale 1ns/100ps
// Operation
// - selector 7 issues a fault reset with every digital-input or panel stop.
// - selector 8 takes fault reset from bit 4 of fieldbus command word one.
// - alternate profile takes fieldbus fault reset from bit 7 of parameter nineteen.
// - selector -1..-5 resets on falling input edge, panel reset still accepted.
// - while locked, panel local/remote key cannot enter local mode.
// - lock selector 0 always permits local mode.
// - lock selector 1..5: rising edge locks, falling edge unlocks.
// - lock selector 7 permanently prevents entering local mode.
// - lock selector resets to second digital input.
// - reset selector 0 panel only; 1..5 rising input edge or panel.
// - reset only when fault cause gone; reset selector defaults to second input.
module reset_lock_select
    import lock_select_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    // APB
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [ADDR_WIDTH-1:0]     paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Digital inputs, first_digital_input in bit 0
    input  wire logic [NUM_DI-1:0]         digital_inputs,
    // Panel key pulses
    input  lock_select_pkg::panel_t        panel,
    // Stop command pulse received through a digital input
    input  wire logic                      di_stop_command,
    // Fieldbus words
    input  lock_select_pkg::fieldbus_t     fieldbus_source,
    // Fault trip side
    input  wire logic                      fault_cause_active,
    output logic                           fault_reset,
    // Control place
    output logic                           lock_active,
    output logic                           local_mode
);
    import lock_select_pkg::*;

    cfg_t              cfg;
    logic [NUM_DI-1:0] di_rise;
    logic [NUM_DI-1:0] di_fall;
    logic [NUM_DI-1:0] reset_hot;
    logic [NUM_DI-1:0] reset_hot_inv;
    logic [NUM_DI-1:0] lock_hot;
    logic [NUM_DI-1:0] lock_hot_inv;
    logic              fb_bit;
    logic              fb_prev;
    logic              fb_rise;
    logic              sel_panel;
    logic              sel_stop;
    logic              sel_fb;
    logic              di_reset_req;
    logic              stop_req;
    logic              panel_ok;
    logic              reset_request;
    logic              next_fault_reset;
    logic              di_lock;
    logic              di_lock_set;
    logic              di_lock_clear;
    logic              lock_by_di;
    logic              next_lock_active;
    logic              next_local_mode;

    apb_cfg_regs u_regs (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .lock_active (lock_active),
        .local_mode  (local_mode),
        .cfg         (cfg)
    );

    input_edge_sync #(
        .WIDTH (NUM_DI)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .raw     (digital_inputs),
        .rise    (di_rise),
        .fall    (di_fall)
    );

    // Per-input selector decode
    genvar k;
    generate
        for (k = 0; k < NUM_DI; k++) begin : g_sel
            assign reset_hot[k]     = (cfg.reset_sel == sel_t'(k + 1));
            assign reset_hot_inv[k] = (cfg.reset_sel == -sel_t'(k + 1));
            assign lock_hot[k]      = (cfg.lock_sel == sel_t'(k + 1));
            assign lock_hot_inv[k]  = (cfg.lock_sel == -sel_t'(k + 1));
        end
    endgenerate

    // Fieldbus reset bit follows the active profile
    assign fb_bit = cfg.alt_profile
                  ? fieldbus_source.embedded_fieldbus_param_nineteen[EFB_RESET_BIT]
                  : fieldbus_source.fieldbus_command_word_one[FB_RESET_BIT];
    assign fb_rise = fb_bit & ~fb_prev;

    assign sel_panel = (cfg.reset_sel == SEL_PANEL);
    assign sel_stop  = (cfg.reset_sel == SEL_STOP);
    assign sel_fb    = (cfg.reset_sel == SEL_FIELDBUS);

    assign di_reset_req = |(di_rise & reset_hot)
                        | |(di_fall & reset_hot_inv);
    assign stop_req     = sel_stop & (di_stop_command | panel.stop_key);
    // Panel reset honoured for every source except the fieldbus
    assign panel_ok     = panel.reset_key & ~sel_fb;

    assign reset_request    = panel_ok | di_reset_req | stop_req | (sel_fb & fb_rise);
    // A reset is only passed on once the trip cause has cleared
    assign next_fault_reset = reset_request & ~fault_cause_active;

    // Inverted inputs: rising of the inverted level (input falls) allows,
    // so both polarities lock on the input's rise and unlock on its fall
    assign di_lock_set   = |(di_rise & (lock_hot | lock_hot_inv));
    assign di_lock_clear = |(di_fall & (lock_hot | lock_hot_inv));
    assign lock_by_di    = |(lock_hot | lock_hot_inv);

    always_comb begin
        next_lock_active = 1'b0;
        if (cfg.lock_sel == SEL_LOCK_OFF)
            next_lock_active = 1'b0;
        else if (cfg.lock_sel == SEL_LOCK_ON)
            next_lock_active = 1'b1;
        else if (cfg.lock_sel == SEL_FIELDBUS)
            next_lock_active = fieldbus_source.fieldbus_command_word_one[FB_LOCK_BIT];
        else if (lock_by_di)
            next_lock_active = di_lock;
    end

    // Leaving local mode is always allowed; entering is blocked by the lock
    always_comb begin
        next_local_mode = local_mode;
        if (panel.local_remote_key) begin
            if (local_mode)
                next_local_mode = 1'b0;
            else if (!lock_active)
                next_local_mode = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_prev <= 1'b0;
            di_lock <= 1'b0;
        end else if (ce) begin
            fb_prev <= fb_bit;
            if (di_lock_set)
                di_lock <= 1'b1;
            else if (di_lock_clear)
                di_lock <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reset <= 1'b0;
            lock_active <= 1'b0;
            local_mode  <= 1'b0;
        end else if (ce) begin
            fault_reset <= next_fault_reset;
            lock_active <= next_lock_active;
            local_mode  <= next_local_mode;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence key_blocked_s;
        ce && panel.local_remote_key && !local_mode && lock_active;
    endsequence

    sequence stop_event_s;
        ce && sel_stop && (di_stop_command || panel.stop_key) && !fault_cause_active;
    endsequence

    stop_reset_a: assert property (stop_event_s |=> fault_reset)
        else $error("stop did not produce a fault reset");

    fb_word_reset_a: assert property (ce && sel_fb && !cfg.alt_profile && !fault_cause_active
        && fieldbus_source.fieldbus_command_word_one[FB_RESET_BIT] && !fb_prev |=> fault_reset)
        else $error("fieldbus command word reset missed");

    fb_alt_reset_a: assert property (ce && sel_fb && cfg.alt_profile && !fault_cause_active
        && fieldbus_source.embedded_fieldbus_param_nineteen[EFB_RESET_BIT] && !fb_prev
        |=> fault_reset)
        else $error("alternate profile reset missed");

    inv_reset_a: assert property (ce && |(di_fall & reset_hot_inv) && !fault_cause_active
        |=> fault_reset)
        else $error("inverted input falling edge did not reset");

    inv_no_rise_a: assert property (ce && |reset_hot_inv && !panel.reset_key
        && !(|di_fall) |=> !fault_reset)
        else $error("inverted selection reset without a falling edge");

    lock_blocks_key_a: assert property (key_blocked_s |=> !local_mode)
        else $error("local mode entered while locked");

    lock_off_a: assert property (ce && cfg.lock_sel == SEL_LOCK_OFF |=> !lock_active)
        else $error("lock active with lock selector zero");

    di_lock_rise_a: assert property (ce && |(di_rise & lock_hot) ##1 ce
        |=> lock_active)
        else $error("rising edge did not lock local control");

    lock_on_a: assert property (ce && cfg.lock_sel == SEL_LOCK_ON
        |=> lock_active ##1 (!ce || cfg.lock_sel != SEL_LOCK_ON || lock_active))
        else $error("permanent lock released");

    defaults_a: assert property ($rose(presetn) |->
        cfg.lock_sel == SEL_DEFAULT && cfg.reset_sel == SEL_DEFAULT)
        else $error("selector defaults wrong after reset");

    panel_only_a: assert property (ce && sel_panel && !panel.reset_key |=> !fault_reset)
        else $error("reset with panel-only selection and no key");

    di_rise_reset_a: assert property (ce && |(di_rise & reset_hot) && !fault_cause_active
        |=> fault_reset)
        else $error("rising input edge did not reset");

    cause_blocks_a: assert property (ce && fault_cause_active |=> !fault_reset)
        else $error("fault reset issued while cause present");

    // Fall without a same-cycle rise: set would win in the latch
    sequence di_unlock_s;
        ce && |(di_fall & (lock_hot | lock_hot_inv))
           && !(|(di_rise & (lock_hot | lock_hot_inv)));
    endsequence

    di_unlock_a: assert property (di_unlock_s ##1 ce |=> !lock_active)
        else $error("falling edge did not release local lock");

    inv_lock_rise_a: assert property (ce && |(di_rise & lock_hot_inv) ##1 ce
        |=> lock_active)
        else $error("inverted lock input rise did not lock");

    key_free_a: assert property (ce && cfg.lock_sel == SEL_LOCK_OFF && !lock_active
        && panel.local_remote_key && !local_mode |=> local_mode)
        else $error("local mode refused with lock selector zero");

    fb_no_edge_a: assert property (ce && sel_fb && !fb_rise |=> !fault_reset)
        else $error("fieldbus selection reset without a bit edge");

    plain_no_fall_a: assert property (ce && |reset_hot && !panel.reset_key
        && !(|di_rise) |=> !fault_reset)
        else $error("plain input selection reset without a rising edge");

    panel_key_a: assert property (ce && !sel_fb && panel.reset_key
        && !fault_cause_active |=> fault_reset)
        else $error("panel reset key ignored");

endmodule : reset_lock_select

//--- far_side_model.sv
// Far-side model: input pins, panel keys and fieldbus command words
`timescale 1ns/100ps
module far_side_model (
    // Clock
    input  wire logic                                  pclk,
    // Far-side signals
    output logic [lock_select_pkg::NUM_DI-1:0]         digital_inputs,
    output lock_select_pkg::panel_t                    panel,
    output logic                                       di_stop_command,
    output lock_select_pkg::fieldbus_t                 fieldbus_source
);
    import lock_select_pkg::*;

    initial begin
        digital_inputs  = '0;
        panel           = '0;
        di_stop_command = 1'b0;
        fieldbus_source = '0;
    end

    task automatic set_di(input int idx, input logic val);
        digital_inputs[idx] <= val;
    endtask : set_di

    // One-cycle pulse; 3 is a stop through a digital input
    task automatic press(input int which);
        if (which == 3) di_stop_command <= 1'b1;
        else panel <= panel_t'(3'b001 << which);
        @(posedge pclk);
        di_stop_command <= 1'b0;
        panel           <= '0;
    endtask : press

    // Words held as levels, as an adapter keeps them
    task automatic set_fb(input logic [15:0] w1, input logic [15:0] w19);
        fieldbus_source <= fieldbus_t'({w1, w19});
    endtask : set_fb
endmodule : far_side_model

//--- tb_top.sv
// Self-checking testbench for fault-reset and local-lock selection
`timescale 1ns/100ps
module tb_top;
    import lock_select_pkg::*;
    logic                  pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic                  fault_cause_active, fault_reset, lock_active, local_mode, di_stop;
    logic [NUM_DI-1:0]     digital_inputs;
    panel_t                panel;
    fieldbus_t             fb;
    logic [31:0]           r;
    int                    cyc, n_errors, tests_run, k;
    int                    exp_q[$];

    initial pclk = 1'b0;
    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    reset_lock_select reset_lock_select_inst (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .digital_inputs(digital_inputs), .panel(panel),
        .di_stop_command(di_stop), .fieldbus_source(fb),
        .fault_cause_active(fault_cause_active), .fault_reset(fault_reset),
        .lock_active(lock_active), .local_mode(local_mode));

    far_side_model far_side_model_inst (
        .pclk(pclk), .digital_inputs(digital_inputs), .panel(panel),
        .di_stop_command(di_stop), .fieldbus_source(fb));

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        tests_run++;
        if (seen !== expv) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask : check

    task automatic complete_run;
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    // Master never assumes a latency; only the bound stops a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check(32'h0, 32'h1);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] expv, input logic experr);
        apb(1'b0, a, 32'h0);
        check(rd, expv);
        check({31'h0, err}, {31'h0, experr});
    endtask : rdchk

    // Latency 0 means no reset pulse may follow
    task automatic note(input int lat);
        @(posedge pclk);
        k = cyc;
        if (lat > 0) exp_q.push_back(k + lat);
    endtask : note

    task automatic press_exp(input int which, input int lat);
        note(lat);
        far_side_model_inst.press(which);
    endtask : press_exp

    task automatic di_exp(input int idx, input logic v, input int lat);
        note(lat);
        far_side_model_inst.set_di(idx, v);
        repeat (3) @(posedge pclk);
    endtask : di_exp

    task automatic fb_exp(input logic [15:0] w1, input logic [15:0] w19, input int lat);
        note(lat);
        far_side_model_inst.set_fb(w1, w19);
        repeat (3) @(posedge pclk);
    endtask : fb_exp

    task automatic key_chk(input logic expv);
        press_exp(0, 0);
        repeat (2) @(posedge pclk);
        check({31'h0, local_mode}, {31'h0, expv});
    endtask : key_chk

    task automatic end_test(input string s);
        repeat (8) @(posedge pclk);
        check(32'(exp_q.size()), 32'h0);
        $display("test %s finished", s);
    endtask : end_test

    // Every reset pulse must match the oldest note, to the cycle
    always @(posedge pclk) begin
        if (presetn === 1'b1 && fault_reset === 1'b1) begin
            if (exp_q.size() == 0) check(32'(cyc), 32'hFFFFFFFF);
            else check(32'(cyc), 32'(exp_q.pop_front()));
        end
    end

    initial begin
        #500000;
        n_errors++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        fault_cause_active = 1'b0;
        cyc = 0;
        n_errors = 0;
        tests_run = 0;
        r = $urandom(32'hDC6ABD6F);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_RESET_SEL, 32'h2, 1'b0);
        rdchk(ADDR_LOCK_SEL, 32'h2, 1'b0);
        rdchk(8'h10, 32'h0, 1'b1);
        rdchk(ADDR_STATUS, 32'h0, 1'b0);
        end_test("reset values");
        wr(ADDR_RESET_SEL, 32'h0);
        di_exp(0, 1'b1, 0);
        di_exp(0, 1'b0, 0);
        press_exp(2, 2);
        @(posedge pclk);
        fault_cause_active <= 1'b1;
        press_exp(2, 0);
        fault_cause_active <= 1'b0;
        // Key pulse while frozen must be lost
        ce <= 1'b0;
        press_exp(2, 0);
        ce <= 1'b1;
        end_test("panel only");
        for (int i = 1; i <= 5; i++) begin
            wr(ADDR_RESET_SEL, 32'(i));
            di_exp(i - 1, 1'b1, 4);
            di_exp(i - 1, 1'b0, 0);
            press_exp(2, 2);
            wr(ADDR_RESET_SEL, 32'(-i));
            rdchk(ADDR_RESET_SEL, 32'(-i), 1'b0);
            di_exp(i - 1, 1'b1, 0);
            di_exp(i - 1, 1'b0, 4);
            press_exp(2, 2);
        end
        end_test("input sources");
        // Fieldbus stays idle while stops are coupled
        wr(ADDR_RESET_SEL, 32'h7);
        press_exp(3, 2);
        press_exp(1, 2);
        end_test("stop coupled");
        wr(ADDR_RESET_SEL, 32'h8);
        r = $urandom();
        fb_exp(r[31:16] & 16'hFFEF, r[15:0] & 16'hFF7F, 0);
        fb_exp(r[31:16] | 16'h0010, r[15:0] & 16'hFF7F, 2);
        fb_exp(r[31:16] & 16'hFFEF, r[15:0] & 16'hFF7F, 0);
        press_exp(2, 0);
        wr(ADDR_CONTROL, 32'h1);
        fb_exp(r[31:16] | 16'h0010, r[15:0] & 16'hFF7F, 0);
        fb_exp(r[31:16] & 16'hFFEF, r[15:0] | 16'h0080, 2);
        fb_exp(16'h0000, 16'h0000, 0);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_RESET_SEL, 32'h0);
        end_test("fieldbus");
        wr(ADDR_LOCK_SEL, 32'h0);
        key_chk(1'b1);
        key_chk(1'b0);
        wr(ADDR_LOCK_SEL, 32'h7);
        repeat (3) @(posedge pclk);
        check({31'h0, lock_active}, 32'h1);
        key_chk(1'b0);
        rdchk(ADDR_STATUS, 32'h1, 1'b0);
        for (int i = 1; i <= 5; i++) begin
            // Plain and inverted selections both lock on the input's rise
            for (int s = 0; s < 2; s++) begin
                wr(ADDR_LOCK_SEL, (s == 0) ? 32'(i) : 32'(-i));
                di_exp(i - 1, 1'b1, 0);
                repeat (8) @(posedge pclk);
                check({31'h0, lock_active}, 32'h1);
                key_chk(1'b0);
                di_exp(i - 1, 1'b0, 0);
                repeat (8) @(posedge pclk);
                check({31'h0, lock_active}, 32'h0);
                key_chk(1'b1);
                key_chk(1'b0);
            end
        end
        wr(ADDR_LOCK_SEL, 32'h8);
        fb_exp(16'h4000, 16'h0000, 0);
        check({31'h0, lock_active}, 32'h1);
        key_chk(1'b0);
        fb_exp(16'h0000, 16'h0000, 0);
        check({31'h0, lock_active}, 32'h0);
        key_chk(1'b1);
        key_chk(1'b0);
        end_test("lock sources");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_LOCK_SEL, 32'h2, 1'b0);
        rdchk(ADDR_RESET_SEL, 32'h2, 1'b0);
        end_test("second reset");
        complete_run();
    end
endmodule : tb_top
